// *** pprc_pkg.sv ***
/*
 * package of the port power and role control block: register map, field
 * positions, reset values, timing counts and carrier types.
 * assumes a 32-bit axi4-lite register bus and seven downstream ports.
 */
package pprc_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] PPRC_REG_CTRL    = 8'h00;
    localparam logic [7:0] PPRC_REG_PORTEN  = 8'h04;
    localparam logic [7:0] PPRC_REG_STATUS  = 8'h08;
    localparam logic [7:0] PPRC_REG_IRQ     = 8'h0C;
    localparam logic [7:0] PPRC_REG_MASK    = 8'h10;
    localparam logic [7:0] PPRC_REG_STRAP   = 8'h14;

    // ==========================================================
    // ctrl fields
    localparam int PPRC_CTRL_GANG  = 0;
    localparam int PPRC_CTRL_RUN   = 1;

    // status fields
    localparam int PPRC_ST_ROLE    = 0;
    localparam int PPRC_ST_VBUS    = 1;
    localparam int PPRC_ST_OC_LSB  = 8;

    // irq fields
    localparam int PPRC_IRQ_OC_LSB = 0;
    localparam int PPRC_IRQ_ROLE   = 7;
    localparam int PPRC_IRQ_VBUS   = 8;
    localparam int PPRC_IRQ_BITS   = 9;

    // ==========================================================
    // reset values
    localparam logic [31:0] PPRC_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] PPRC_PORTEN_RST = 32'h0000_007F;

    // ==========================================================
    // timing: overcurrent debounce
    localparam int PPRC_CLK_HZ       = 50_000_000;
    localparam int PPRC_OC_DEB_US    = 1;
    localparam int PPRC_OC_DEB_CYC   = (PPRC_OC_DEB_US * PPRC_CLK_HZ + 999_999) / 1_000_000;

    // axi responses
    localparam logic [1:0] PPRC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PPRC_RESP_SLVERR = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [6:0] i;
        logic [6:0] o;
        logic [6:0] oe;
        logic [6:0] pu;
        logic [6:0] pd;
    } pprc_ports_t;

    typedef struct packed {
        logic [6:0] plus;
        logic [6:0] minus;
    } pprc_strap_t;

    typedef enum logic [1:0] {
        PPRC_IDLE,
        PPRC_RESP
    } pprc_wr_t;

endpackage

// *** pprc_top.sv ***
/*
 * port power, overcurrent sense and role swap control of a seven-port hub,
 * with an axi4-lite register slave and a level interrupt.
 * assumes all pins are asynchronous to aclk and resolved by the pad ring
 * from the enables and pull controls given here.
 */
`timescale 1ns/1ps

module pprc_top import pprc_pkg::*; #(
    parameter int NPORT    = 7,
    parameter int DEB_CYC  = PPRC_OC_DEB_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [7:0]        s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    input  wire logic [6:0]        port_power_line_i,
    output logic [6:0]             port_power_line_o,
    output logic [6:0]             port_power_line_oe,
    output logic [6:0]             port_power_line_pu,
    output logic [6:0]             port_power_line_pd,
    input  wire logic              shared_power_ctl_i,
    output logic                   shared_power_ctl_o,
    output logic                   shared_power_ctl_oe,
    input  wire logic              role_swap_cmd,
    output logic                   role_swap_ind,
    output logic                   role_swap_ind_oe,
    input  wire logic              upstream_power_detect,
    output logic                   upstream_connect,
    input  wire logic [6:0]        port_off_strap_plus,
    input  wire logic [6:0]        port_off_strap_minus,
    output logic                   strap_pd_en,
    output logic                   upstream_hs_data_pd_en,
    output logic                   mem_ce_pu_en,
    output logic [6:0]             port_oc,
    output logic                   irq
);

    // ==========================================================
    // elaboration checks: the logic serves seven ports and an 8-bit debounce counter
    if (NPORT != 7) begin : g_nport_check
        $error("NPORT must be 7");
    end
    if (DEB_CYC < 1 || DEB_CYC > 255) begin : g_deb_check
        $error("DEB_CYC out of range");
    end

    // ==========================================================
    // reset-time pad controls
    // the chip reset is the aresetn input; everything below holds while low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_pd_en            <= 1'b1;
            upstream_hs_data_pd_en <= 1'b1;
            mem_ce_pu_en           <= 1'b1;
        end else begin
            strap_pd_en            <= 1'b0;
            upstream_hs_data_pd_en <= 1'b0;
            mem_ce_pu_en           <= 1'b0;
        end
    end

    // ==========================================================
    // input synchronisers
    logic [6:0] oc_s1, oc_s2;
    logic       gang_s1, gang_s2, cmd_s1, cmd_s2, vb_s1, vb_s2;
    logic [6:0] sp_s1, sp_s2, sm_s1, sm_s2;

    always_ff @(posedge aclk) begin
        oc_s1   <= port_power_line_i;
        oc_s2   <= oc_s1;
        gang_s1 <= shared_power_ctl_i;
        gang_s2 <= gang_s1;
        cmd_s1  <= role_swap_cmd;
        cmd_s2  <= cmd_s1;
        vb_s1   <= upstream_power_detect;
        vb_s2   <= vb_s1;
        sp_s1   <= port_off_strap_plus;
        sp_s2   <= sp_s1;
        sm_s1   <= port_off_strap_minus;
        sm_s2   <= sm_s1;
    end

    // ==========================================================
    // strap latch: first cycle after reset release
    logic       rst_q;
    logic [6:0] strap_off;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_q     <= 1'b1;
            strap_off <= 7'h00;
        end else begin
            rst_q <= 1'b0;
            if (rst_q) begin
                strap_off <= sp_s2 & sm_s2;
            end
        end
    end

    // ==========================================================
    // registers
    logic [31:0] ctrl, porten;
    logic [8:0]  irq_st, irq_mask;
    logic        gang_mode, run;
    logic [6:0]  port_on;

    assign gang_mode = ctrl[PPRC_CTRL_GANG];
    assign run       = ctrl[PPRC_CTRL_RUN];
    assign port_on   = porten[6:0] & ~strap_off & {7{run}};

    // ==========================================================
    // overcurrent debounce per port
    logic [6:0] oc_raw;
    logic [7:0] deb_cnt [7];

    always_comb begin
        for (int p = 0; p < 7; p++) begin
            if (gang_mode) begin
                // the shared pin reports overcurrent only while it is not driven low here
                oc_raw[p] = port_on[p] & ~shared_power_ctl_oe & ~gang_s2;
            end else begin
                oc_raw[p] = port_on[p] & ~oc_s2[p];
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int p = 0; p < 7; p++) begin
            if (!aresetn || !oc_raw[p]) begin
                deb_cnt[p] <= 8'h00;
                port_oc[p] <= 1'b0;
            end else if (deb_cnt[p] == 8'(DEB_CYC - 1)) begin
                port_oc[p] <= 1'b1;
            end else begin
                deb_cnt[p] <= deb_cnt[p] + 8'h01;
            end
        end
    end

    // ==========================================================
    // pin drive
    always_comb begin
        if (!aresetn) begin
            port_power_line_oe  = 7'h00;
            port_power_line_pu  = 7'h00;
            port_power_line_pd  = 7'h7F;
            shared_power_ctl_oe = 1'b0;
        end else if (gang_mode) begin
            port_power_line_oe  = 7'h00;
            port_power_line_pu  = 7'h00;
            port_power_line_pd  = 7'h00;
            shared_power_ctl_oe = ~port_on[0];
        end else begin
            port_power_line_oe  = ~port_on;
            port_power_line_pu  = port_on;
            port_power_line_pd  = 7'h00;
            shared_power_ctl_oe = 1'b0;
        end
    end
    assign port_power_line_o  = 7'h00;
    assign shared_power_ctl_o = 1'b0;

    // ==========================================================
    // role swap and bus power
    logic role, vb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            role             <= 1'b0;
            role_swap_ind_oe <= 1'b0;
            vb_q             <= 1'b0;
            upstream_connect <= 1'b0;
        end else begin
            role             <= cmd_s2;
            role_swap_ind_oe <= 1'b1;
            // one cycle behind the connect output, so a change raises an event
            vb_q             <= upstream_connect;
            upstream_connect <= vb_s2;
        end
    end
    assign role_swap_ind = role;

    // ==========================================================
    // interrupt status: set wins over clear
    logic [8:0] ev, oc_q, wclr;
    logic       role_q, wr_fire;
    logic [7:0] wa;
    logic [31:0] wd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc_q   <= 9'h000;
            role_q <= 1'b0;
        end else begin
            oc_q   <= {2'b00, port_oc};
            role_q <= role;
        end
    end
    assign ev = {vb_q ^ upstream_connect, role ^ role_q, port_oc & ~oc_q[6:0]};
    assign wclr = (wr_fire && wa == PPRC_REG_IRQ) ? wd[8:0] : 9'h000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st <= 9'h000;
        end else begin
            irq_st <= (irq_st & ~wclr) | ev;
        end
    end
    assign irq = |(irq_st & irq_mask);

    // ==========================================================
    // axi4-lite write
    logic aw_h, w_h;

    assign s_awready = ~aw_h & ~s_bvalid;
    assign s_wready  = ~w_h & ~s_bvalid;
    assign wr_fire   = aw_h & w_h & ~s_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            if (st[b]) old[8*b +: 8] = nw[8*b +: 8];
        end
        return old;
    endfunction

    logic [3:0] ws;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h     <= 1'b0;
            w_h      <= 1'b0;
            wa       <= 8'h00;
            wd       <= 32'h0000_0000;
            ws       <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp  <= PPRC_RESP_OKAY;
            ctrl     <= PPRC_CTRL_RST;
            porten   <= PPRC_PORTEN_RST;
            irq_mask <= 9'h000;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_h <= 1'b1;
                wa   <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_h <= 1'b1;
                wd  <= s_wdata;
                ws  <= s_wstrb;
            end
            if (wr_fire) begin
                aw_h     <= 1'b0;
                w_h      <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= PPRC_RESP_OKAY;
                unique case (wa)
                    PPRC_REG_CTRL:   ctrl     <= merge(ctrl, wd, ws) & 32'h0000_0003;
                    PPRC_REG_PORTEN: porten   <= merge(porten, wd, ws) & 32'h0000_007F;
                    PPRC_REG_MASK:   irq_mask <= 9'(merge({23'h0, irq_mask}, wd, ws));
                    PPRC_REG_IRQ, PPRC_REG_STATUS, PPRC_REG_STRAP: ;
                    default:         s_bresp  <= PPRC_RESP_SLVERR;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi4-lite read
    assign s_arready = ~s_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= PPRC_RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= PPRC_RESP_OKAY;
            s_rdata  <= 32'h0000_0000;
            unique case (s_araddr)
                PPRC_REG_CTRL:   s_rdata <= ctrl;
                PPRC_REG_PORTEN: s_rdata <= porten;
                PPRC_REG_STATUS: s_rdata <= {17'h0, port_oc, 6'h0, vb_q, role};
                PPRC_REG_IRQ:    s_rdata <= {23'h0, irq_st};
                PPRC_REG_MASK:   s_rdata <= {23'h0, irq_mask};
                PPRC_REG_STRAP:  s_rdata <= {25'h0, strap_off};
                default:         s_rresp <= PPRC_RESP_SLVERR;
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // assertions
    a_disabled_drives_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (!gang_mode && !port_on[3]) |-> (port_power_line_oe[3] && !port_power_line_o[3]))
        else $error("disabled port not driven low");
    a_enabled_pullup: assert property (@(posedge aclk) disable iff (!aresetn)
        (!gang_mode && port_on[2]) |-> (port_power_line_pu[2] && !port_power_line_oe[2]))
        else $error("enabled port lacks pull-up");
    a_gang_pins_free: assert property (@(posedge aclk) disable iff (!aresetn)
        gang_mode |-> (port_power_line_oe == 7'h00))
        else $error("port pin driven in ganged mode");
    a_role_follows_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(cmd_s2) |=> role_swap_ind)
        else $error("indicator did not follow command");
    a_role_default: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cmd_s2 [*3]) |-> !role_swap_ind)
        else $error("flexed while command low");
    a_flexed_state: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_s2 [*3]) |-> role_swap_ind)
        else $error("default while command high");
    a_oc_debounce: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(port_oc[0]) |-> $past(oc_raw[0], DEB_CYC))
        else $error("overcurrent flagged before debounce");
    a_oc_needs_port: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(port_oc[1]) |-> $past(port_on[1]))
        else $error("overcurrent flagged on a disabled port");
    a_reset_pulls: assert property (@(posedge aclk)
        !aresetn |-> (port_power_line_pd == 7'h7F && port_power_line_oe == 7'h00))
        else $error("reset pad state wrong");
    a_reset_ind_off: assert property (@(posedge aclk)
        !aresetn |=> !role_swap_ind_oe)
        else $error("indicator driven during reset");
    a_reset_pad_pulls: assert property (@(posedge aclk)
        !aresetn |=> (strap_pd_en && upstream_hs_data_pd_en && mem_ce_pu_en))
        else $error("reset pull enables missing");
    a_strap_held: assert property (@(posedge aclk) disable iff (!aresetn)
        !rst_q |=> $stable(strap_off))
        else $error("strap latch changed outside reset release");
    a_connect_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(vb_s2) |=> upstream_connect)
        else $error("connect did not rise with bus power");
    a_vbus_connect: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(vb_s2) |=> !upstream_connect)
        else $error("connect did not drop with bus power");
    a_irq_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        (|ev) |=> ((irq_st & $past(ev)) == $past(ev)))
        else $error("interrupt event lost");
    a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wa == PPRC_REG_IRQ && ev == 9'h000) |=> ((irq_st & $past(wd[8:0])) == 9'h000))
        else $error("interrupt status not cleared by write");

endmodule // pprc_top

// *** pprc_switch_model.sv ***
/*
 * behavioural model of the external port power switches and current
 * monitors that share each port power line with the hub.
 * assumes the bench feeds the resolved line levels back into the design.
 */
`timescale 1ns/1ps

module pprc_switch_model (
    input  wire logic       aclk,
    input  wire logic [6:0] oc_req,
    input  wire logic [6:0] line_o,
    input  wire logic [6:0] line_oe,
    input  wire logic [6:0] line_pu,
    input  wire logic [6:0] line_pd,
    input  wire logic       sh_o,
    input  wire logic       sh_oe,
    output logic      [6:0] line_lvl,
    output logic            sh_lvl,
    output logic      [6:0] power_on
);
    // ==========================================================
    // line resolution
    logic flip = 1'h0;

    always_ff @(posedge aclk) begin
        flip <= ~flip;
    end

    always_comb begin
        for (int k = 0; k < 7; k++) begin
            if (line_oe[k])
                line_lvl[k] = line_o[k];    // hub drives a disabled port
            else if (oc_req[k])
                line_lvl[k] = 1'h0;         // monitor pulls low on overcurrent
            else if (line_pu[k])
                line_lvl[k] = 1'h1;         // hub pull-up holds the line high
            else if (line_pd[k])
                line_lvl[k] = 1'h0;         // hub pull-down keeps power off
            else
                line_lvl[k] = flip;
        end
    end

    // switch conducts while its enable line is high
    assign power_on = line_lvl;
    // board pull-up on the shared line
    assign sh_lvl   = sh_oe ? sh_o : 1'h1;
endmodule // pprc_switch_model

// *** tb.sv ***
/*
 * self-checking bench of the port power and role control block.
 * assumes the switch model and the design package are compiled first.
 */
`timescale 1ns/1ps

module tb import pprc_pkg::*; ();
    logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, shared_power_ctl_i, shared_power_ctl_o;
    logic        shared_power_ctl_oe, role_swap_cmd, role_swap_ind, role_swap_ind_oe;
    logic        upstream_power_detect, upstream_connect, strap_pd_en, upstream_hs_data_pd_en;
    logic        mem_ce_pu_en, irq;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdv;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rsp;
    logic [6:0]  port_power_line_i, port_power_line_o, port_power_line_oe, port_power_line_pu;
    logic [6:0]  port_power_line_pd, port_off_strap_plus, port_off_strap_minus, port_oc, oc_req, pwr;
    int          failures, check_count, seed, ctrl, porten, off, ist, mask, p;

    pprc_top #(.DEB_CYC(4)) i_pprc_top (.*);
    pprc_switch_model i_pprc_switch_model (.aclk(aclk), .oc_req(oc_req), .line_o(port_power_line_o),
        .line_oe(port_power_line_oe), .line_pu(port_power_line_pu), .line_pd(port_power_line_pd),
        .sh_o(shared_power_ctl_o), .sh_oe(shared_power_ctl_oe), .line_lvl(port_power_line_i),
        .sh_lvl(shared_power_ctl_i), .power_on(pwr));

    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end

    // ==========================================================
    // helpers
    function automatic logic [6:0] on_exp();
        return ctrl[1] ? 7'(porten & ~off) : 7'h00;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        bit ka, kw, kd;
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= w;
        s_wvalid <= w;
        s_arvalid <= !w;
        while (n < 40) begin
            @(negedge aclk);
            ka = w ? s_awvalid && s_awready : s_arvalid && s_arready;
            kw = s_wvalid && s_wready;
            kd = w ? s_bvalid === 1'h1 : s_rvalid === 1'h1;
            rdv = s_rdata;
            rsp = w ? s_bresp : s_rresp;
            @(posedge aclk);
            if (ka && w)
                s_awvalid <= 1'h0;
            if (ka && !w)
                s_arvalid <= 1'h0;
            if (kw)
                s_wvalid <= 1'h0;
            if (kd)
                break;
            n++;
        end
        if (n == 40)
            failures++;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0, 4'h0);
        chk(nm, e, rdv);
        chk("read resp", PPRC_RESP_OKAY, rsp);
    endtask

    task automatic pins(input bit r);
        @(negedge aclk);
        chk("pad state", r ? {7'h7F, 14'h0, 1'h0, 3'h7, 2'h0} : {7'h0, 7'h7F, 7'h0, 1'h1, 5'h0},
            {port_power_line_pd, port_power_line_oe, port_power_line_pu, role_swap_ind_oe, strap_pd_en,
             upstream_hs_data_pd_en, mem_ce_pu_en, shared_power_ctl_oe, irq & r});
    endtask

    task automatic ports();
        @(negedge aclk);
        chk("pull up", on_exp(), port_power_line_pu);
        chk("drive low", 7'h7F ^ on_exp(), port_power_line_oe);
        chk("port power", on_exp(), pwr);
    endtask

    task automatic status(input int oc);
        @(negedge aclk);
        chk("overcurrent", oc, port_oc);
        chk("irq line", (ist & mask) != 0, irq);
        rchk("status", PPRC_REG_STATUS, (oc << 8) | (upstream_power_detect << 1) | role_swap_cmd);
        rchk("irq status", PPRC_REG_IRQ, ist);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        complete_run();
    end

    // ==========================================================
    // tests
    initial begin
        seed = 32'hDC33B0E4;
        failures = 0;
        check_count = 0;
        aresetn = 1'h0;
        {s_awvalid, s_wvalid, s_arvalid, role_swap_cmd, oc_req} = '0;
        {s_bready, s_rready, upstream_power_detect} = 3'h7;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {port_off_strap_plus, port_off_strap_minus} = 14'h0;
        {ctrl, porten, off, ist, mask} = {32'h0, 32'h7F, 96'h0};
        @(posedge aclk);
        pins(1'h1);
        @(posedge aclk);
        aresetn <= 1'h1;
        tick(2);
        pins(1'h0);
        rchk("ctrl", PPRC_REG_CTRL, PPRC_CTRL_RST);
        rchk("port enable", PPRC_REG_PORTEN, PPRC_PORTEN_RST);
        bus(1'h1, 8'h40, 32'h1, 4'hF);
        chk("unmapped write", PPRC_RESP_SLVERR, rsp);
        bus(1'h0, 8'h40, 32'h0, 4'h0);
        chk("unmapped read", PPRC_RESP_SLVERR, rsp);
        $display("test reset done");
        ctrl = 2;
        bus(1'h1, PPRC_REG_CTRL, 32'h2, 4'hF);
        for (int i = 0; i < 6; i++) begin
            p = $random(seed);
            if (!i[0])
                porten = p & 'h7F;
            bus(1'h1, PPRC_REG_PORTEN, p, i[0] ? 4'hE : 4'h1);
            tick(2);
            ports();
            rchk("port enable", PPRC_REG_PORTEN, porten);
        end
        for (int i = 0; i < 2; i++) begin
            porten = i ? 'h7E : 'h7F;
            bus(1'h1, PPRC_REG_PORTEN, porten, 4'hF);
            bus(1'h1, PPRC_REG_CTRL, 32'h3, 4'hF);
            tick(2);
            @(negedge aclk);
            chk("shared line", i * 2, {shared_power_ctl_oe, shared_power_ctl_o});
            bus(1'h1, PPRC_REG_CTRL, 32'h2, 4'hF);
        end
        $display("test port power done");
        porten = 'h7F;
        mask = 'h1FF;
        bus(1'h1, PPRC_REG_PORTEN, 32'h7F, 4'hF);
        bus(1'h1, PPRC_REG_MASK, 32'h1FF, 4'hF);
        bus(1'h1, PPRC_REG_IRQ, 32'h1FF, 4'hF);
        p = {$random(seed)} % 7;
        @(posedge aclk);
        oc_req[p] <= 1'h1;
        @(posedge aclk);
        oc_req[p] <= 1'h0;
        tick(12);
        status(0);
        @(posedge aclk);
        oc_req[p] <= 1'h1;
        tick(12);
        ist = 1 << p;
        status(1 << p);
        @(posedge aclk);
        oc_req[p] <= 1'h0;
        tick(12);
        status(0);
        mask = 0;
        bus(1'h1, PPRC_REG_MASK, 32'h0, 4'hF);
        status(0);
        mask = 'h1FF;
        ist = 0;
        bus(1'h1, PPRC_REG_MASK, 32'h1FF, 4'hF);
        bus(1'h1, PPRC_REG_IRQ, 1 << p, 4'hF);
        status(0);
        $display("test overcurrent done");
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            if (i < 2)
                role_swap_cmd <= ~role_swap_cmd;
            else
                upstream_power_detect <= ~upstream_power_detect;
            tick(8);
            ist = ist | (i < 2 ? 'h80 : 'h100);
            @(negedge aclk);
            chk("role", role_swap_cmd, role_swap_ind);
            chk("connect", upstream_power_detect, upstream_connect);
            status(0);
        end
        $display("test role and bus power done");
        p = $random(seed);
        @(posedge aclk);
        aresetn <= 1'h0;
        port_off_strap_plus <= p[6:0];
        port_off_strap_minus <= p[13:7];
        tick(4);
        pins(1'h1);
        @(posedge aclk);
        aresetn <= 1'h1;
        {ctrl, porten, off} = {32'h0, 32'h7F, 25'h0, p[6:0] & p[13:7]};
        tick(2);
        pins(1'h0);
        @(posedge aclk);
        {port_off_strap_plus, port_off_strap_minus} <= 14'h3FFF;
        ctrl = 2;
        bus(1'h1, PPRC_REG_CTRL, 32'h2, 4'hF);
        tick(4);
        ports();
        rchk("strap", PPRC_REG_STRAP, off);
        $display("test strap latch done");
        complete_run();
    end
endmodule // tb
